// ==== include/qr_timing_pkg.sv ====
// ============================================================
// Timing, scaling and register map
package qr_timing_pkg;
    // ============================================================
    // Clock
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS = 40;

    // ============================================================
    // Times in their own units, cycle counts derived from them
    localparam int unsigned SS_STEP_MS = 4;
    localparam int unsigned SS_TOTAL_MS = 12;
    localparam int unsigned SS_STEP_CYC = CLK_HZ / 1000 * SS_STEP_MS;
    localparam int unsigned UPDATE_MS = 48;
    localparam int unsigned UPDATE_CYC = CLK_HZ / 1000 * UPDATE_MS;
    localparam int unsigned LEB_NS = 330;
    localparam int unsigned LEB_CYC = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RING_NS = 2000;
    localparam int unsigned RING_CYC = (RING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MAX_PERIOD_US = 50;
    localparam int unsigned MAX_PERIOD_CYC = CLK_HZ / 1_000_000 * MAX_PERIOD_US;

    // ============================================================
    // Widths
    localparam int unsigned LONG_W = 21;
    localparam int unsigned SHORT_W = 11;
    localparam int unsigned FB_W = 12;
    localparam int unsigned CS_W = 10;
    localparam int unsigned ZC_W = 12;

    // ============================================================
    // Valley target range
    localparam logic [2:0] UD_MIN = 3'h1;
    localparam logic [2:0] UD_MAX = 3'h7;

    // ============================================================
    // Current-sense scaling; gain, offset and soft-start limits in tenths of a millivolt
    localparam logic [15:0] CS_GAIN_X10 = 16'h0021;
    localparam logic [15:0] CS_OFFSET_X10 = 16'h1B58;
    localparam logic [15:0] FB_SCALE = 16'h000A;
    localparam logic [15:0] SS_REF1_X10 = 16'h3415;
    localparam logic [15:0] SS_REF2_X10 = 16'h682B;
    localparam logic [15:0] SS_REF3_X10 = 16'h9C40;
    localparam logic [1:0] SS_DONE = 2'h3;

    // ============================================================
    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_LOW = 5'h04;
    localparam logic [4:0] REG_MID = 5'h08;
    localparam logic [4:0] REG_HIGH = 5'h0C;
    localparam logic [4:0] REG_VALLEY = 5'h10;
    localparam logic [4:0] REG_STATUS = 5'h14;

    // ============================================================
    // Field positions and reset values
    localparam int unsigned CTRL_BURST_BIT = 0;
    localparam int unsigned CTRL_GATE_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;
    localparam int unsigned ST_UD_LSB = 0;
    localparam int unsigned ST_ZC_LSB = 4;
    localparam int unsigned ST_SS_LSB = 8;
    localparam int unsigned ST_GATE_BIT = 12;
    localparam int unsigned ST_RUN_BIT = 13;
    localparam int unsigned ST_FLAG_LSB = 16;
    localparam logic [11:0] LOW_RESET = 12'h7D0;
    localparam logic [11:0] MID_RESET = 12'h9C4;
    localparam logic [11:0] HIGH_RESET = 12'hED8;
    localparam logic [11:0] VALLEY_RESET = 12'h064;

    // ============================================================
    // Switch states
    typedef enum logic [1:0] {
        ST_WAIT,
        ST_ON,
        ST_OFF
    } sw_state_t;
endpackage : qr_timing_pkg

// ==== rtl/qr_switch_timing.sv ====
// Decided for this implementation: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
module qr_switch_timing #(
    parameter int unsigned SS_STEP_CYC = qr_timing_pkg::SS_STEP_CYC,
    parameter int unsigned UPDATE_CYC = qr_timing_pkg::UPDATE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Sensed levels from outside the clock domain: a supply flag, a millivolt feedback code, current-sense and valley codes
    input wire logic supply_turn_on_level,
    input wire logic [11:0] regulation_input,
    input wire logic [9:0] cs_level,
    input wire logic [11:0] valley_sense_input,
    // Power stage
    output logic gate_drive,
    output logic startup_path_en,
    output logic overload_prot_en,
    output logic [1:0] soft_start_step
);
    // ============================================================
    // Input synchronisers
    logic supply_s;
    logic [11:0] fb_s;
    logic [9:0] cs_s;
    logic [11:0] zc_s;

    sync_two_stage #(.W(35)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({supply_turn_on_level, regulation_input, cs_level, valley_sense_input}),
        .sync_out({supply_s, fb_s, cs_s, zc_s})
    );

    // ============================================================
    // Registers
    logic [1:0] ctrl_q;
    logic [11:0] low_thr_q;
    logic [11:0] mid_thr_q;
    logic [11:0] high_thr_q;
    logic [11:0] valley_thr_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] status;
    logic wr_fire;

    function automatic logic [11:0] merge12(input logic [11:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge12 = {be[1] ? wd[11:8] : old[11:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : merge12

    // One wait cycle per access; write lands and read data stand at the releasing edge
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_fire = avs_write && ack_q;
    assign avs_readdata = rdata_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= qr_timing_pkg::CTRL_RESET;
            low_thr_q <= qr_timing_pkg::LOW_RESET;
            mid_thr_q <= qr_timing_pkg::MID_RESET;
            high_thr_q <= qr_timing_pkg::HIGH_RESET;
            valley_thr_q <= qr_timing_pkg::VALLEY_RESET;
        end else if (wr_fire) begin
            case (avs_address)
                qr_timing_pkg::REG_CTRL: begin
                    if (avs_byteenable[0]) begin
                        ctrl_q <= avs_writedata[1:0];
                    end
                end
                qr_timing_pkg::REG_LOW: low_thr_q <= merge12(low_thr_q, avs_writedata, avs_byteenable);
                qr_timing_pkg::REG_MID: mid_thr_q <= merge12(mid_thr_q, avs_writedata, avs_byteenable);
                qr_timing_pkg::REG_HIGH: high_thr_q <= merge12(high_thr_q, avs_writedata, avs_byteenable);
                qr_timing_pkg::REG_VALLEY: begin
                    valley_thr_q <= merge12(valley_thr_q, avs_writedata, avs_byteenable);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && !ack_q) begin
            case (avs_address)
                qr_timing_pkg::REG_CTRL: rdata_q <= {30'h0, ctrl_q};
                qr_timing_pkg::REG_LOW: rdata_q <= {20'h0, low_thr_q};
                qr_timing_pkg::REG_MID: rdata_q <= {20'h0, mid_thr_q};
                qr_timing_pkg::REG_HIGH: rdata_q <= {20'h0, high_thr_q};
                qr_timing_pkg::REG_VALLEY: rdata_q <= {20'h0, valley_thr_q};
                qr_timing_pkg::REG_STATUS: rdata_q <= status;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ============================================================
    // Comparisons
    logic burst_q;
    logic burst_prev_q;
    logic [15:0] fb_x10;
    logic [15:0] cs_x10;
    logic [15:0] limit_x10;
    logic [1:0] ss_step_q;
    logic cs_trip;
    logic fb_above_low;
    logic fb_above_mid;
    logic fb_above_high;
    logic zc_below;

    assign burst_q = ctrl_q[qr_timing_pkg::CTRL_BURST_BIT];
    assign fb_x10 = {4'h0, fb_s} * qr_timing_pkg::FB_SCALE;
    assign cs_x10 = {6'h00, cs_s} * qr_timing_pkg::CS_GAIN_X10 + qr_timing_pkg::CS_OFFSET_X10;
    assign fb_above_low = fb_s > low_thr_q;
    assign fb_above_mid = fb_s > mid_thr_q;
    assign fb_above_high = fb_s > high_thr_q;
    assign zc_below = zc_s < valley_thr_q;

    always_comb begin
        case (ss_step_q)
            2'h0: limit_x10 = qr_timing_pkg::SS_REF1_X10;
            2'h1: limit_x10 = qr_timing_pkg::SS_REF2_X10;
            2'h2: limit_x10 = qr_timing_pkg::SS_REF3_X10;
            default: limit_x10 = fb_x10;
        endcase
    end
    assign cs_trip = cs_x10 > limit_x10;

    // ============================================================
    // Soft-start
    logic [qr_timing_pkg::LONG_W-1:0] ss_cnt_q;
    qr_timing_pkg::sw_state_t state_q;
    qr_timing_pkg::sw_state_t state_d;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ss_cnt_q <= '0;
            ss_step_q <= 2'h0;
        end else if (state_q == qr_timing_pkg::ST_WAIT) begin
            ss_cnt_q <= '0;
            ss_step_q <= 2'h0;
        end else if (ss_step_q != qr_timing_pkg::SS_DONE) begin
            if (ss_cnt_q == qr_timing_pkg::LONG_W'(SS_STEP_CYC - 1)) begin
                ss_cnt_q <= '0;
                ss_step_q <= ss_step_q + 2'h1;
            end else begin
                ss_cnt_q <= ss_cnt_q + 1'b1;
            end
        end
    end

    // ============================================================
    // Switch state
    logic [qr_timing_pkg::SHORT_W-1:0] phase_q;
    logic [2:0] zc_cnt_q;
    logic [2:0] ud;
    logic zc_below_q;
    logic blank_done;
    logic ring_done;
    logic max_expired;
    logic valley_evt;
    logic valley_ok;
    logic turn_on;
    logic gate_q;

    assign blank_done = phase_q >= qr_timing_pkg::SHORT_W'(qr_timing_pkg::LEB_CYC);
    assign ring_done = phase_q >= qr_timing_pkg::SHORT_W'(qr_timing_pkg::RING_CYC);
    assign max_expired = phase_q >= qr_timing_pkg::SHORT_W'(qr_timing_pkg::MAX_PERIOD_CYC - 1);
    assign valley_evt = zc_below && !zc_below_q && ring_done;
    assign valley_ok = zc_cnt_q == ud && zc_below && ring_done;
    // Burst blocks both sources; the max-period path must not leak pulses either
    assign turn_on = state_q == qr_timing_pkg::ST_OFF && !burst_q
        && ctrl_q[qr_timing_pkg::CTRL_GATE_EN_BIT] && (valley_ok || max_expired);

    always_comb begin
        state_d = state_q;
        case (state_q)
            qr_timing_pkg::ST_WAIT: begin
                if (supply_s) begin
                    state_d = qr_timing_pkg::ST_OFF;
                end
            end
            qr_timing_pkg::ST_ON: begin
                if (blank_done && cs_trip) begin
                    state_d = qr_timing_pkg::ST_OFF;
                end
            end
            qr_timing_pkg::ST_OFF: begin
                if (turn_on) begin
                    state_d = qr_timing_pkg::ST_ON;
                end
            end
            default: state_d = qr_timing_pkg::ST_WAIT;
        endcase
        if (!supply_s) begin
            state_d = qr_timing_pkg::ST_WAIT;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= qr_timing_pkg::ST_WAIT;
            gate_q <= 1'b0;
            startup_path_en <= 1'b1;
            overload_prot_en <= 1'b0;
        end else begin
            state_q <= state_d;
            gate_q <= state_d == qr_timing_pkg::ST_ON;
            startup_path_en <= state_d == qr_timing_pkg::ST_WAIT;
            overload_prot_en <= state_d != qr_timing_pkg::ST_WAIT
                && ss_step_q == qr_timing_pkg::SS_DONE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= '0;
        end else if (state_d != state_q) begin
            phase_q <= '0;
        end else if (!max_expired) begin
            phase_q <= phase_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            zc_cnt_q <= 3'h0;
            zc_below_q <= 1'b0;
        end else begin
            zc_below_q <= zc_below;
            if (state_d == qr_timing_pkg::ST_OFF && state_q != qr_timing_pkg::ST_OFF) begin
                zc_cnt_q <= 3'h0;
            end else if (state_q == qr_timing_pkg::ST_OFF && valley_evt
                         && zc_cnt_q != qr_timing_pkg::UD_MAX) begin
                zc_cnt_q <= zc_cnt_q + 3'h1;
            end
        end
    end

    assign gate_drive = gate_q;
    assign soft_start_step = ss_step_q;

    // ============================================================
    // Load tracking and valley target
    logic [qr_timing_pkg::LONG_W-1:0] upd_cnt_q;
    logic [2:0] seen_q;
    logic [2:0] seen_now;
    logic upd_tick;
    logic force_pend_q;
    logic burst_exit;
    logic force_now;

    assign upd_tick = upd_cnt_q == qr_timing_pkg::LONG_W'(UPDATE_CYC - 1);
    assign seen_now = seen_q | {fb_above_high, fb_above_mid, fb_above_low};
    assign burst_exit = burst_prev_q && !burst_q;
    assign force_now = (force_pend_q && turn_on) || burst_exit;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            upd_cnt_q <= '0;
            seen_q <= 3'h0;
            force_pend_q <= 1'b0;
            burst_prev_q <= 1'b0;
        end else begin
            burst_prev_q <= burst_q;
            upd_cnt_q <= upd_tick ? '0 : upd_cnt_q + 1'b1;
            // A crossing in the clearing cycle opens the next period
            seen_q <= upd_tick ? {fb_above_high, fb_above_mid, fb_above_low} : seen_now;
            force_pend_q <= fb_above_high || (force_pend_q && !turn_on);
        end
    end

    valley_target_counter u_target (
        .clk(clk),
        .sys_rst(sys_rst),
        .count_up(upd_tick && !seen_now[0]),
        .count_down(upd_tick && seen_now[1] && !seen_now[2]),
        .load_one(force_now),
        .value(ud)
    );

    assign status = {13'h0, seen_q, 2'h0, state_q != qr_timing_pkg::ST_WAIT, gate_q,
                     2'h0, ss_step_q, 1'b0, zc_cnt_q, 1'b0, ud};

    // ============================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_startup_path_off: assert property (state_q != qr_timing_pkg::ST_WAIT
        |-> !startup_path_en)
        else $error("start-up path on while switching");
    a_ss_step_advance: assert property ((state_q != qr_timing_pkg::ST_WAIT && supply_s
        && ss_step_q != qr_timing_pkg::SS_DONE
        && ss_cnt_q == qr_timing_pkg::LONG_W'(SS_STEP_CYC - 1))
        |=> ss_step_q == $past(ss_step_q) + 2'h1)
        else $error("soft-start step did not advance on time");
    a_ovl_masked_ss: assert property (ss_step_q != qr_timing_pkg::SS_DONE
        |=> !overload_prot_en || $past(ss_step_q) == 2'h2)
        else $error("overload protection live in soft-start");
    a_ud_one_step: assert property (!force_now
        |=> ud == $past(ud) || ud == $past(ud) + 3'h1 || ud + 3'h1 == $past(ud))
        else $error("target moved more than one step");
    a_ud_idle_stable: assert property ((!upd_tick && !force_now) |=> $stable(ud))
        else $error("target moved between updates");
    a_fast_load_one: assert property (($rose(gate_q) && $past(force_pend_q)) |-> ud == 3'h1)
        else $error("fast load did not force the target to one");
    a_turn_on_cause: assert property ($rose(gate_q) |-> $past(valley_ok || max_expired))
        else $error("turn-on without valley match or max period");
    a_burst_no_on: assert property ((burst_q && state_q == qr_timing_pkg::ST_OFF)
        |=> state_q != qr_timing_pkg::ST_ON)
        else $error("turn-on during burst mode");
    a_ring_mask_zc: assert property ((state_q == qr_timing_pkg::ST_OFF && !ring_done
        && state_d == qr_timing_pkg::ST_OFF) |=> $stable(zc_cnt_q))
        else $error("valley counted inside ringing suppression");
    a_trip_turn_off: assert property ((state_q == qr_timing_pkg::ST_ON && blank_done
        && cs_trip && supply_s) |=> !gate_q)
        else $error("current trip did not end the pulse");
    a_blank_min_on: assert property ($rose(gate_q) |-> gate_q[*8])
        else $error("pulse shorter than blanking");
    a_burst_exit_one: assert property ($fell(burst_q) |=> ud == 3'h1)
        else $error("target not one after burst exit");
    a_bus_wait: assert property ((avs_read && !ack_q) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer timing wrong");

    c_ss_done: cover property ($rose(ss_step_q == qr_timing_pkg::SS_DONE));
    c_valley_on: cover property ($rose(gate_q) && $past(valley_ok) && ud == 3'h3);
    c_max_on: cover property ($rose(gate_q) && $past(max_expired && !valley_ok));
    c_burst_exit: cover property ($fell(burst_q));
endmodule : qr_switch_timing

// ==== rtl/sync_two_stage.sv ====
`timescale 1ns/10ps
// ============================================================
// Two-flop synchroniser, one pair per bit
module sync_two_stage #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // Multi-bit codes may skew by one cycle between bits; callers accept that
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_q;
        logic stab_q;
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                meta_q <= 1'b0;
                stab_q <= 1'b0;
            end else begin
                meta_q <= async_in[i];
                stab_q <= meta_q;
            end
        end
        assign sync_out[i] = stab_q;
    end
endmodule : sync_two_stage

// ==== rtl/valley_target_counter.sv ====
`timescale 1ns/10ps
// ============================================================
// Saturating up/down counter holding the turn-on valley number
module valley_target_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Commands
    input wire logic count_up,
    input wire logic count_down,
    input wire logic load_one,
    // Value
    output logic [2:0] value
);
    logic [2:0] value_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            value_q <= qr_timing_pkg::UD_MIN;
        end else if (load_one) begin
            value_q <= qr_timing_pkg::UD_MIN;
        end else if (count_up && value_q != qr_timing_pkg::UD_MAX) begin
            value_q <= value_q + 3'h1;
        end else if (count_down && value_q != qr_timing_pkg::UD_MIN) begin
            value_q <= value_q - 3'h1;
        end
    end

    assign value = value_q;

    // ============================================================
    // Checks
    a_ud_range_held: assert property (@(posedge clk) disable iff (sys_rst)
        value_q >= qr_timing_pkg::UD_MIN && value_q <= qr_timing_pkg::UD_MAX)
        else $error("valley target left its range");
    a_ud_sat_top: assert property (@(posedge clk) disable iff (sys_rst)
        (value_q == qr_timing_pkg::UD_MAX && count_up && !load_one) |=> value_q == 3'h7)
        else $error("counting above the top changed the value");
endmodule : valley_target_counter

// ==== testbench/power_stage_model.sv ====
`timescale 1ns/10ps
// ============================================================
// Switch current and auxiliary winding
module power_stage_model (
    // Clock and gate
    input wire logic clk,
    input wire logic gate_drive,
    // Sensed levels
    output logic [9:0] cs_level,
    output logic [11:0] valley_sense_input
);
    logic [7:0] off_cyc;
    initial begin
        cs_level = 10'h000;
        valley_sense_input = 12'h3E8;
        off_cyc = 8'h00;
    end
    // Ramp saturates so a high limit can still be reached
    always @(posedge clk) begin
        cs_level <= !gate_drive ? 10'h000 : (cs_level >= 10'h3C0 ? 10'h3FF : cs_level + 10'h040);
        off_cyc <= gate_drive ? 8'h00 : off_cyc + 8'h01;
    end
    // Some valleys fall inside ring suppression on purpose
    always @(posedge clk) begin
        valley_sense_input <= (off_cyc > 8'h28 && off_cyc[3]) ? 12'h014 : 12'h3E8;
    end
endmodule : power_stage_model

// ==== testbench/qr_switch_timing_tb_top.sv ====
`timescale 1ns/10ps
module qr_switch_timing_tb_top;
    logic clk, sys_rst, sup, rq_rd, rq_wr, wreq, gate, spath, ovl;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] ss;
    logic [11:0] fb, vly;
    logic [9:0] cs;
    int failures, compares, n;
    qr_switch_timing #(.SS_STEP_CYC(20), .UPDATE_CYC(64)) dut (.clk(clk), .sys_rst(sys_rst),
        .avs_address(addr), .avs_read(rq_rd), .avs_write(rq_wr), .avs_writedata(wdata),
        .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .supply_turn_on_level(sup), .regulation_input(fb), .cs_level(cs),
        .valley_sense_input(vly), .gate_drive(gate), .startup_path_en(spath),
        .overload_prot_en(ovl), .soft_start_step(ss));
    power_stage_model ps (.clk(clk), .gate_drive(gate), .cs_level(cs), .valley_sense_input(vly));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ============================================================
    // Helpers
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Waitrequest and read data are taken at the same edge
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        rq_rd <= !wr;
        rq_wr <= wr;
        addr <= a;
        wdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        rd = rdata;
        rq_rd <= 1'b0;
        rq_wr <= 1'b0;
        // One idle edge so the next call never raises a strobe in this time step
        @(posedge clk);
        if (n >= 20) begin
            failures++;
            give_verdict();
        end
    endtask : bus
    // Counts gate-high cycles over a window
    task gate_cycles(input int len);
        n = 0;
        repeat (len) begin
            @(posedge clk);
            if (gate) n++;
        end
    endtask : gate_cycles
    // ============================================================
    // Sequence
    initial begin
        failures = 0;
        compares = 0;
        sys_rst = 1'b1;
        {sup, rq_rd, rq_wr, addr, wdata} = '0;
        fb = 12'h5DC;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check({spath, gate, ovl, ss}, 32'h10);
        bus(1'b0, 5'h00, 32'h0);
        check(rd, 32'h2);
        bus(1'b0, 5'h18, 32'h0);
        check(rd, 32'h0);
        $display("reset test done");
        sup <= 1'b1;
        repeat (6) @(posedge clk);
        check(spath, 1'b0);
        n = 0;
        repeat (80) begin
            @(posedge clk);
            if (ss !== 2'h3) begin
                n++;
                check(ovl, 1'b0);
            end
        end
        check(n >= 45 && n <= 60, 1'b1);
        check(ovl, 1'b1);
        // Let a pulse in progress finish, then catch a whole pulse from its rise
        n = 0;
        while (gate && n < 3000) begin
            @(posedge clk);
            n++;
        end
        while (!gate && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) begin
            failures++;
            give_verdict();
        end
        gate_cycles(30);
        check(n + 1 >= 10 && n + 1 <= 13, 1'b1);
        repeat (600) @(posedge clk);
        bus(1'b0, 5'h14, 32'h0);
        check(rd[2:0], 3'h7);
        fb <= 12'hFA0;
        gate_cycles(1400);
        check(n > 0, 1'b1);
        bus(1'b0, 5'h14, 32'h0);
        check(rd[2:0], 3'h1);
        $display("valley test done");
        fb <= 12'h5DC;
        bus(1'b1, 5'h00, 32'h3);
        repeat (40) @(posedge clk);
        gate_cycles(1500);
        check(n, 0);
        bus(1'b0, 5'h14, 32'h0);
        check(rd[2:0], 3'h7);
        // Hold band, so only the exit load can move the target
        fb <= 12'h898;
        bus(1'b1, 5'h00, 32'h2);
        bus(1'b0, 5'h14, 32'h0);
        check(rd[2:0], 3'h1);
        $display("burst test done");
        give_verdict();
    end
endmodule : qr_switch_timing_tb_top
